// File: timer_prescaler_pkg.sv
package timer_prescaler_pkg;

	// Register locations and reset values
	localparam logic [4:0] timer_count_addr    = 5'h01;
	localparam logic [7:0] option_reset        = 8'hff;
	localparam logic [5:0] pin_direction_reset = 6'h3f;
	localparam logic [7:0] prescaler_reset     = 8'h00;
	localparam logic [7:0] count_reset         = 8'h00;

	// Option field positions
	localparam int clock_source_bit = 5;
	localparam int edge_select_bit  = 4;
	localparam int owner_select_bit = 3;
	localparam int ratio_hi_bit     = 2;

	// Shared pin position in the direction register
	localparam int shared_pin_bit = 2;

	// Inhibit length after a count write, in instruction cycles
	localparam logic [1:0] write_inhibit_cycles = 2'h2;

	// Four-phase sequencing
	typedef enum logic [1:0] {
		phase_first_s,
		phase_second_s,
		phase_third_s,
		phase_fourth_s
	} phase_t;

	// Register write strobes from the core
	typedef struct packed {
		logic       count_we;
		logic       option_we;
		logic       direction_we;
		logic       watchdog_clear;
		logic [7:0] wdata;
	} core_wr_t;

	// Everything the block holds
	typedef struct packed {
		phase_t     phase;
		logic [7:0] count;
		logic [7:0] option;
		logic [5:0] direction;
		logic [7:0] prescaler;
		logic       pin_prev;
		logic       sample_q2;
		logic       sample_q4;
		logic       sync_prev;
		logic [1:0] inhibit;
	} state_t;

endpackage

// File: timer_prescaler.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: Source bit picks instruction cycles or pin edges
// RQ2: Edge bit: clear rising, set falling
// RQ3: Count write blocks increments two cycles
// RQ4: Owner bit clear gives prescaler to timer
// RQ5: Unassigned prescaler passes pin straight through
// RQ6: Prescaler output sampled on second, fourth phases
// RQ7: Source holds each level two oscillator periods
// RQ8: Assigned prescaler divides pin before sampling
// RQ9: Prescaled input period at least four periods
// RQ10: Count steps after synchronised edge registered
// RQ11: External count mode forces shared pin input
// RQ12: One counter: timer prescaler or watchdog postscaler
// RQ13: Option low nibble selects owner and ratio
// RQ14: Count writes clear prescaler when timer-owned
// RQ15: Watchdog clear clears prescaler when watchdog-owned
// RQ16: Prescaler has no software read or write
// RQ17: Any reset zeroes the prescaler
// RQ18: Assignment may change at any time
// RQ19: Software sequence for timer to watchdog
// RQ20: Software sequence for watchdog to timer
// RQ21: Count register at address one, kept otherwise
// RQ22: Option register resets to all ones
// RQ23: Ratio code n divides by two to n+1
module timer_prescaler (
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire timer_prescaler_pkg::core_wr_t core_wr,
	input  wire logic                         count_input_pin,
	input  wire logic                         watchdog_tick,
	output logic [7:0]                        timer_count,
	output logic [7:0]                        option_control,
	output logic [5:0]                        pin_direction,
	output logic                              shared_pin_input,
	output logic                              watchdog_scaled_tick,
	output logic                              instr_cycle_end
);

	timer_prescaler_pkg::state_t s_r;
	timer_prescaler_pkg::state_t s_nxt;

	logic       timer_owned;
	logic       ext_mode;
	logic       falling_sel;
	logic       is_phase_second;
	logic       is_phase_fourth;
	logic       pin_edge;
	logic       scaler_clk;
	logic       scaler_tick;
	logic       prescaler_out;
	logic       rise_seen;
	logic       sync_rise;
	logic       step;
	logic [2:0] ratio;
	logic [7:0] scaler_next;

	////////////////////////////////////////////////////////////////////////
	// Option decode
	assign ext_mode    = s_r.option[timer_prescaler_pkg::clock_source_bit];    // [RQ1]
	assign falling_sel = s_r.option[timer_prescaler_pkg::edge_select_bit];     // [RQ2]
	assign timer_owned = ~s_r.option[timer_prescaler_pkg::owner_select_bit];   // [RQ4] [RQ13]
	assign ratio       = s_r.option[timer_prescaler_pkg::ratio_hi_bit:0];      // [RQ13]

	// Phase decode, shared by sampling, the prescaler clock and the cycle-end output
	assign is_phase_second = (s_r.phase == timer_prescaler_pkg::phase_second_s);
	assign is_phase_fourth = (s_r.phase == timer_prescaler_pkg::phase_fourth_s);

	////////////////////////////////////////////////////////////////////////
	// Counted edge of the pin, polarity chosen by the edge bit
	always_comb begin
		if (falling_sel) begin
			pin_edge = s_r.pin_prev & ~count_input_pin; // [RQ2]
		end else begin
			pin_edge = ~s_r.pin_prev & count_input_pin; // [RQ2]
		end
	end

	// Prescaler clock: pin edges or cycle ends for the timer, watchdog ticks otherwise
	always_comb begin
		if (!timer_owned) begin
			scaler_clk = watchdog_tick; // [RQ12]
		end else if (ext_mode) begin
			scaler_clk = pin_edge; // [RQ8]
		end else begin
			scaler_clk = is_phase_fourth; // [RQ4]
		end
	end

	// Ripple step of the shared counter
	assign scaler_next = s_r.prescaler + 8'h01;

	// Prescaler output: ratio bit of the counter, or the pin in counted polarity
	always_comb begin
		if (timer_owned && ext_mode) begin
			prescaler_out = s_r.prescaler[ratio]; // [RQ8] [RQ23]
		end else begin
			prescaler_out = count_input_pin ^ falling_sel; // [RQ5] [RQ2]
		end
	end

	// Terminal event of the scaler in its internal uses
	assign scaler_tick = scaler_clk & s_r.prescaler[ratio] & ~scaler_next[ratio];

	////////////////////////////////////////////////////////////////////////
	// Synchroniser rise detect over samples two clocks apart,
	// so a level held two clocks is never missed
	always_comb begin
		rise_seen = 1'b0;
		if (!s_r.sample_q4 && s_r.sample_q2) begin
			rise_seen = 1'b1; // [RQ6]
		end
		if (!s_r.sample_q2 && prescaler_out) begin
			rise_seen = 1'b1; // [RQ6]
		end
	end

	// Registered rise of the previous cycle drives the step
	assign sync_rise = s_r.sync_prev; // [RQ10]

	////////////////////////////////////////////////////////////////////////
	// Timer step selection
	always_comb begin
		step = 1'b0;
		if (s_r.phase == timer_prescaler_pkg::phase_fourth_s) begin
			if (ext_mode) begin
				step = sync_rise; // [RQ1] [RQ10]
			end else if (timer_owned) begin
				step = scaler_tick; // [RQ4]
			end else begin
				step = 1'b1; // [RQ1]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		s_nxt          = s_r;
		s_nxt.phase    = timer_prescaler_pkg::phase_t'(s_r.phase + 2'h1);
		s_nxt.pin_prev = count_input_pin;

		// Sample on second and fourth phases; rise held for the next step
		if (is_phase_second) begin
			s_nxt.sample_q2 = prescaler_out; // [RQ6]
		end
		if (is_phase_fourth) begin
			s_nxt.sample_q4 = prescaler_out; // [RQ6]
			s_nxt.sync_prev = rise_seen;     // [RQ10]
		end

		// Prescaler advance; no software path into it
		if (scaler_clk) begin
			s_nxt.prescaler = scaler_next; // [RQ16]
		end

		// Counter increments and post-write inhibit
		if (s_r.phase == timer_prescaler_pkg::phase_fourth_s && s_r.inhibit != 2'h0) begin
			s_nxt.inhibit = s_r.inhibit - 2'h1; // [RQ3]
		end else if (step) begin
			s_nxt.count = s_r.count + 8'h01;
		end

		// Core writes; assignment may change at any cycle
		if (core_wr.option_we) begin
			s_nxt.option = core_wr.wdata; // [RQ18]
		end
		if (core_wr.direction_we) begin
			s_nxt.direction = core_wr.wdata[5:0];
		end
		if (core_wr.count_we) begin
			s_nxt.count   = core_wr.wdata;
			s_nxt.inhibit = timer_prescaler_pkg::write_inhibit_cycles; // [RQ3]
			if (timer_owned) begin
				s_nxt.prescaler = timer_prescaler_pkg::prescaler_reset; // [RQ14]
			end
		end
		if (core_wr.watchdog_clear && !timer_owned) begin
			s_nxt.prescaler = timer_prescaler_pkg::prescaler_reset; // [RQ15]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r.phase     <= timer_prescaler_pkg::phase_first_s;
			s_r.count     <= timer_prescaler_pkg::count_reset;
			s_r.option    <= timer_prescaler_pkg::option_reset;        // [RQ22]
			s_r.direction <= timer_prescaler_pkg::pin_direction_reset;
			s_r.prescaler <= timer_prescaler_pkg::prescaler_reset;     // [RQ17]
			s_r.pin_prev  <= 1'b0;
			// Samples start high: reset option counts falling edges of an idle-low pin
			s_r.sample_q2 <= 1'b1;
			s_r.sample_q4 <= 1'b1;
			s_r.sync_prev <= 1'b0;
			s_r.inhibit   <= 2'h0;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register outputs
	assign timer_count          = s_r.count; // [RQ21]
	assign option_control       = s_r.option;
	assign pin_direction        = s_r.direction;

	// Shared pin forced to input in external count mode
	assign shared_pin_input     = ext_mode | s_r.direction[timer_prescaler_pkg::shared_pin_bit]; // [RQ11]

	// Watchdog event, scaled only when it owns the prescaler
	assign watchdog_scaled_tick = timer_owned ? watchdog_tick : scaler_tick; // [RQ12]

	// End of each instruction cycle
	assign instr_cycle_end      = is_phase_fourth;

endmodule

// File: timer_prescaler_chk_sva.sv
`timescale 1ns/1ps
module timer_prescaler_chk (
	input wire logic                          clk_sys,
	input wire logic                          rst,
	input wire timer_prescaler_pkg::core_wr_t core_wr,
	input wire logic                          watchdog_tick,
	input wire logic [7:0]                    timer_count,
	input wire logic [7:0]                    option_control,
	input wire logic [5:0]                    pin_direction,
	input wire logic                          shared_pin_input,
	input wire logic                          watchdog_scaled_tick,
	input wire logic                          instr_cycle_end
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Loads, steps and the inhibit window after a count write
	property p_opt; core_wr.option_we |=> option_control == $past(core_wr.wdata); endproperty
	a_opt: assert property (p_opt) else $error("option load wrong");
	property p_cnt; core_wr.count_we |=> timer_count == $past(core_wr.wdata); endproperty
	a_cnt: assert property (p_cnt) else $error("count load wrong");
	property p_inc; $changed(timer_count) && !$past(core_wr.count_we)
		|-> timer_count == $past(timer_count) + 8'h01 && $past(instr_cycle_end); endproperty
	a_inc: assert property (p_inc) else $error("count step wrong");
	property p_inh; core_wr.count_we ##1 (!core_wr.count_we)[*8] |-> timer_count == $past(core_wr.wdata, 8);
	endproperty
	a_inh: assert property (p_inh) else $error("step during inhibit");
	property p_phase; instr_cycle_end |=> (!instr_cycle_end)[*3] ##1 instr_cycle_end; endproperty
	a_phase: assert property (p_phase) else $error("phase cycle wrong");
	// Owner split and pin direction override
	property p_wd; !option_control[3] |-> watchdog_scaled_tick == watchdog_tick; endproperty
	a_wd: assert property (p_wd) else $error("watchdog scaled");
	property p_wdsub; option_control[3] && watchdog_scaled_tick |-> watchdog_tick; endproperty
	a_wdsub: assert property (p_wdsub) else $error("scaled tick without watchdog tick");
	property p_ext; option_control[5] |-> shared_pin_input; endproperty
	a_ext: assert property (p_ext) else $error("pin not input");
	property p_dir; !option_control[5] |-> shared_pin_input == pin_direction[2]; endproperty
	a_dir: assert property (p_dir) else $error("pin direction wrong");
endmodule
bind timer_prescaler timer_prescaler_chk u_chk (.clk_sys, .rst, .core_wr, .watchdog_tick, .timer_count,
	.option_control, .pin_direction, .shared_pin_input, .watchdog_scaled_tick, .instr_cycle_end);

// File: count_source.sv
`timescale 1ns/1ps
module count_source #(parameter int half = 3) (
	input  wire logic       clk_sys,
	input  wire logic       go,
	input  wire logic [4:0] edges,
	output logic            pin
);
	// Toggles the pin, each level held half clocks
	initial begin
		pin = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (go) begin
				repeat (edges) begin
					repeat (half) @(negedge clk_sys);
					pin = ~pin;
				end
			end
		end
	end
endmodule

// File: tb_timer_prescaler.sv
`timescale 1ns/1ps
module tb_timer_prescaler;
	logic                          clk_sys;
	logic                          rst = 1'b1;
	timer_prescaler_pkg::core_wr_t core_wr = '0;
	logic                          count_input_pin;
	logic                          watchdog_tick = 1'b0;
	logic [7:0]                    timer_count;
	logic [7:0]                    option_control;
	logic                          shared_pin_input;
	logic                          src_go = 1'b0;
	logic [4:0]                    src_edges = 5'h00;
	logic [31:0]                   seed = 32'd90853;
	logic [7:0]                    v;
	logic                          s;
	int                            k;
	int                            n;
	int                            errors = 0;
	int                            checks_done = 0;
	int                            cycles = 0;
	timer_prescaler uut (.clk_sys, .rst, .core_wr, .count_input_pin, .watchdog_tick, .timer_count,
		.option_control, .pin_direction(), .shared_pin_input, .watchdog_scaled_tick(), .instr_cycle_end());
	count_source src (.clk_sys, .go(src_go), .edges(src_edges), .pin(count_input_pin));
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int n_edges(input logic st, input logic ed, input int t);
		return (st == ed) ? (t + 1) / 2 : t / 2;
	endfunction
	task automatic stop_test();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [3:0] we, input logic [7:0] d);
		@(negedge clk_sys);
		core_wr = {we, d};
		@(negedge clk_sys);
		core_wr = '0;
	endtask
	// Watchdog ticks and hang guard
	always @(negedge clk_sys) watchdog_tick <= (cycles % 7 == 0);
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		cmp(option_control, 8'hff, 8'hff);
		wr(4'h4, 8'h08);
		v = 8'(rnd());
		wr(4'h8, v);
		repeat (40) @(negedge clk_sys);
		cmp(timer_count, v + 8'h08, v + 8'h08);
		wr(4'h1, 8'h00);
		for (k = 0; k < 8; k++) begin
			wr(4'h4, 8'(k));
			wr(4'h8, 8'h00);
			repeat (32 << k) @(negedge clk_sys);
			cmp(timer_count, 8'h03, 8'h04);
		end
		wr(4'h1, 8'h00);
		wr(4'h8, 8'h00);
		wr(4'h4, 8'h0f);
		wr(4'h2, 8'h00);
		for (k = 0; k < 6; k++) begin
			v = 8'(rnd());
			wr(4'h4, {3'h1, v[0], v[1], 3'h0});
			wr(4'h8, 8'h00);
			repeat (12) @(negedge clk_sys);
			s = count_input_pin;
			src_edges = {1'b0, v[5:2]} + 5'h01;
			src_go = 1'b1;
			@(negedge clk_sys);
			src_go = 1'b0;
			repeat (72) @(negedge clk_sys);
			n = n_edges(s, v[0], int'(src_edges));
			cmp(timer_count, 8'(v[1] ? n : n / 2), 8'(v[1] ? n : (n + 1) / 2));
			cmp({7'h00, shared_pin_input}, 8'h01, 8'h01);
		end
		wr(4'h4, 8'h08);
		cmp({7'h00, shared_pin_input}, 8'h00, 8'h00);
		stop_test();
	end
endmodule
